// ==== design/rlck_loader.sv ====
/*
 * Power-up loader and vendor key detector for the resource and patch RAMs.
 * Assumes a byte-read front end that answers each request with one pulse.
 */
// Functional notes
// - Resource RAM holds 384 bytes; header is four
// - Read first two bytes after power-up
// - 55h then BBh loads remaining contents
// - Bad header: memory absent, nothing loaded
// - Keep defaults; accept host-load writes otherwise
// - Loading finishes before plug-and-play participation
// - Header, length, 19 configuration bytes
// - Identifier, version, string follow configuration
// - Logical devices, end tag, checksum, patch
// - Patch code goes to core RAM
// - Full key enters configuration mode
// - Fixed 32-byte key compared in order
// - Standard key and vendor key disable
// - Codec DMA 8-bit, byte count, type A
// - Default codec, synth, legacy base requests
// - Watch every write to address port; the detector only sees them after loading and while the vendor key is enabled
// - Length field high byte first
`timescale 1ns/10ps
`default_nettype none
`include "rlck_defs.svh"
module rlck_loader #(
    parameter int RAM_BYTES   = 384,
    parameter int PATCH_BYTES = 640
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_srst,
    output rlck_pkg::rlck_rd_req_t       o_ee_req,
    input  wire logic                    i_ee_rd_valid,
    input  wire logic [7:0]              i_ee_rd_data,
    input  wire logic                    i_host_io_wr,
    input  wire logic [15:0]             i_host_io_addr,
    input  wire logic [7:0]              i_host_io_data,
    input  wire logic                    i_hostload_wr,
    input  wire logic [8:0]              i_hostload_addr,
    input  wire logic [7:0]              i_hostload_data,
    input  wire logic [8:0]              i_res_rd_addr,
    output logic [7:0]                   o_res_rd_data,
    input  wire logic [9:0]              i_patch_rd_addr,
    output logic [7:0]                   o_patch_rd_data,
    input  wire logic                    i_cfg_exit,
    input  wire logic                    i_pnp_key_disable,
    input  wire logic                    i_vendor_key_disable,
    output logic                         o_load_done,
    output logic                         o_ee_present,
    output logic                         o_pnp_ready,
    output logic                         o_config_mode,
    output logic                         o_pnp_key_enabled,
    output logic [15:0]                  o_res_length,
    output rlck_pkg::rlck_defaults_t     o_defaults
);
    // ------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------
    // Vendor key bytes
    localparam logic [7:0] KEY [0:31] = '{
        8'h96, 8'h35, 8'h9A, 8'hCD, 8'hE6, 8'hF3, 8'h79, 8'hBC,
        8'h5E, 8'hAF, 8'h57, 8'h2B, 8'h15, 8'h8A, 8'hC5, 8'hE2,
        8'hF1, 8'hF8, 8'h7C, 8'h3E, 8'h9F, 8'h4F, 8'h27, 8'h13,
        8'h09, 8'h84, 8'h42, 8'hA1, 8'hD0, 8'h68, 8'h34, 8'h1A};
    // ------------------------------------------------------------
    // Loader state
    // ------------------------------------------------------------
    rlck_pkg::rlck_state_t state;
    rlck_pkg::rlck_state_t next_state;
    logic [11:0]           addr;
    logic [11:0]           next_addr;
    logic                  pending;
    logic                  next_pending;
    logic [15:0]           length;
    logic [15:0]           next_length;
    logic                  present;
    logic                  next_present;
    logic [7:0]            res_ram   [0:RAM_BYTES-1];
    logic [7:0]            patch_ram [0:PATCH_BYTES-1];
    logic [11:0]           res_end;
    logic                  res_wr;
    logic [8:0]            res_wr_addr;
    logic [7:0]            res_wr_data;
    logic                  patch_wr;
    logic [9:0]            patch_wr_addr;
    // Copy stops at length or RAM capacity, whichever is less
    assign res_end = (length > 16'(`RLCK_RAM_BYTES)) ? `RLCK_RAM_BYTES + `RLCK_HDR_BYTES
                                                      : length[11:0] + `RLCK_HDR_BYTES;
    always_comb begin
        next_state   = state;
        next_addr    = addr;
        next_pending = pending;
        next_length  = length;
        next_present = present;
        res_wr       = 1'b0;
        patch_wr     = 1'b0;
        res_wr_addr  = 9'h000;
        res_wr_data  = i_ee_rd_data;
        patch_wr_addr = 10'h000;
        if (i_ee_rd_valid) begin
            next_pending = 1'b0;
        end
        case (state)
            rlck_pkg::RLCK_IDLE: begin
                // Probe the first bytes after reset
                next_state   = rlck_pkg::RLCK_HDR;
                next_addr    = 12'h000;
                next_pending = 1'b1;
            end
            rlck_pkg::RLCK_HDR: begin
                if (i_ee_rd_valid) begin
                    if ((addr == 12'h000 && i_ee_rd_data != `RLCK_VALID_BYTE0) ||
                        (addr == 12'h001 && i_ee_rd_data != `RLCK_VALID_BYTE1)) begin
                        next_state = rlck_pkg::RLCK_DONE;
                    end else begin
                        next_addr    = addr + 12'h001;
                        next_pending = 1'b1;
                        if (addr == 12'h001) begin
                            next_state = rlck_pkg::RLCK_LEN;
                        end
                    end
                end
            end
            rlck_pkg::RLCK_LEN: begin
                if (i_ee_rd_valid) begin
                    next_length  = {length[7:0], i_ee_rd_data};
                    next_addr    = addr + 12'h001;
                    next_pending = 1'b1;
                    if (addr == 12'h003) begin
                        next_present = 1'b1;
                        next_state   = rlck_pkg::RLCK_COPY;
                    end
                end
            end
            rlck_pkg::RLCK_COPY: begin
                if (i_ee_rd_valid) begin
                    // Image copied verbatim in layout order
                    res_wr       = 1'b1;
                    res_wr_addr  = 9'(addr - `RLCK_HDR_BYTES);
                    next_addr    = addr + 12'h001;
                    next_pending = 1'b1;
                    if (next_addr >= res_end) begin
                        next_state = rlck_pkg::RLCK_PATCH;
                    end
                end else if (addr >= res_end) begin
                    next_state = rlck_pkg::RLCK_PATCH;
                end
            end
            rlck_pkg::RLCK_PATCH: begin
                if (i_ee_rd_valid) begin
                    // Trailing bytes feed the core patch RAM
                    patch_wr      = 1'b1;
                    patch_wr_addr = 10'(addr - res_end);
                    next_addr     = addr + 12'h001;
                    next_pending  = 1'b1;
                    if (next_addr - res_end >= 12'(PATCH_BYTES) ||
                        next_addr >= `RLCK_IMG_MAX_BYTES) begin
                        next_state   = rlck_pkg::RLCK_DONE;
                        next_pending = 1'b0;
                    end
                end
            end
            rlck_pkg::RLCK_DONE: begin
                next_pending = 1'b0;
                // Without memory the host may replace resource data
                if (i_hostload_wr && !present) begin
                    res_wr      = 1'b1;
                    res_wr_addr = i_hostload_addr;
                    res_wr_data = i_hostload_data;
                end
            end
            default: begin
                next_state = rlck_pkg::RLCK_IDLE;
            end
        endcase
    end
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state   <= rlck_pkg::RLCK_IDLE;
            addr    <= 12'h000;
            pending <= 1'b0;
            length  <= 16'h0000;
            present <= 1'b0;
        end else begin
            state   <= next_state;
            addr    <= next_addr;
            pending <= next_pending;
            length  <= next_length;
            present <= next_present;
        end
    end
    // ------------------------------------------------------------
    // Memories
    // ------------------------------------------------------------
    // Bounded resource store; built-in defaults live in the ROM side
    always_ff @(posedge i_clk) begin
        if (res_wr && res_wr_addr < 9'(RAM_BYTES)) begin
            res_ram[res_wr_addr] <= res_wr_data;
        end
        if (patch_wr) begin
            patch_ram[patch_wr_addr] <= i_ee_rd_data;
        end
        o_res_rd_data   <= res_ram[i_res_rd_addr];
        o_patch_rd_data <= patch_ram[i_patch_rd_addr];
    end
    // ------------------------------------------------------------
    // Key detector
    // ------------------------------------------------------------
    logic [5:0] key_idx;
    logic [5:0] next_key_idx;
    logic       cfg_mode;
    logic       next_cfg_mode;
    logic       pnp_en;
    logic       next_pnp_en;
    logic       vkey_en;
    logic       next_vkey_en;
    logic       ap_wr;
    // Address port writes feed the detector only after loading is done and while the vendor key is enabled
    assign ap_wr = i_host_io_wr && i_host_io_addr == `RLCK_ADDR_PORT;
    always_comb begin
        next_key_idx  = key_idx;
        next_cfg_mode = cfg_mode;
        next_pnp_en   = pnp_en;
        next_vkey_en  = vkey_en;
        if (i_pnp_key_disable) begin
            next_pnp_en = 1'b0;
        end
        if (i_vendor_key_disable) begin
            next_vkey_en = 1'b0;
        end
        if (i_cfg_exit) begin
            next_cfg_mode = 1'b0;
        end
        if (ap_wr && vkey_en && state == rlck_pkg::RLCK_DONE) begin
            if (i_host_io_data == KEY[key_idx[4:0]]) begin
                next_key_idx = key_idx + 6'h01;
                if (key_idx == `RLCK_KEY_LEN - 6'h01) begin
                    next_cfg_mode = 1'b1;
                    next_key_idx  = 6'h00;
                end
            end else if (i_host_io_data == KEY[0]) begin
                next_key_idx = 6'h01;
            end else begin
                next_key_idx = 6'h00;
            end
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            key_idx  <= 6'h00;
            cfg_mode <= 1'b0;
            pnp_en   <= 1'b1;
            vkey_en  <= 1'b1;
        end else begin
            key_idx  <= next_key_idx;
            cfg_mode <= next_cfg_mode;
            pnp_en   <= next_pnp_en;
            vkey_en  <= next_vkey_en;
        end
    end
    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_ee_req.valid    = pending && !i_ee_rd_valid;
    assign o_ee_req.addr     = addr;
    assign o_load_done       = state == rlck_pkg::RLCK_DONE;
    assign o_ee_present      = present;
    assign o_pnp_ready       = state == rlck_pkg::RLCK_DONE && pnp_en;
    assign o_config_mode     = cfg_mode;
    assign o_pnp_key_enabled = pnp_en;
    assign o_res_length      = length;
    assign o_defaults = '{
        codec_io_base:        `RLCK_CODEC_BASE,
        codec_len:            `RLCK_CODEC_LEN,
        codec_align:          `RLCK_CODEC_ALIGN,
        synth_io_base:        `RLCK_SYNTH_BASE,
        synth_len:            `RLCK_SYNTH_LEN,
        synth_align:          `RLCK_SYNTH_ALIGN,
        legacy_audio_io_base: `RLCK_LEGACY_BASE,
        legacy_len:           `RLCK_LEGACY_LEN,
        legacy_align:         `RLCK_LEGACY_ALIGN,
        dma_8bit:             `RLCK_DMA_WIDTH8,
        dma_count_by_byte:    `RLCK_DMA_BYTECNT,
        dma_timing:           `RLCK_DMA_TYPE_A};
endmodule
`default_nettype wire

// ==== design/rlck_defs.svh ====
/*
 * Constants for the resource loader and configuration key detector.
 * Assumes inclusion by bare name from package and design files.
 */
`ifndef RLCK_DEFS_SVH
`define RLCK_DEFS_SVH

`define RLCK_VALID_BYTE0   8'h55
`define RLCK_VALID_BYTE1   8'hBB
`define RLCK_HDR_BYTES     12'h004
`define RLCK_RAM_BYTES     12'h180
`define RLCK_IMG_MAX_BYTES 12'h400
`define RLCK_KEY_LEN       6'h20
`define RLCK_ADDR_PORT     16'h0279
`define RLCK_CODEC_BASE    16'h0534
`define RLCK_SYNTH_BASE    16'h0388
`define RLCK_LEGACY_BASE   16'h0220
`define RLCK_CODEC_LEN     8'h04
`define RLCK_CODEC_ALIGN   8'h04
`define RLCK_SYNTH_LEN     8'h04
`define RLCK_SYNTH_ALIGN   8'h08
`define RLCK_LEGACY_LEN    8'h10
`define RLCK_LEGACY_ALIGN  8'h20
`define RLCK_DMA_WIDTH8    1'b1
`define RLCK_DMA_BYTECNT   1'b1
`define RLCK_DMA_TYPE_A    2'h1

`endif

// ==== design/rlck_pkg.sv ====
/*
 * Types for the resource loader and configuration key detector.
 * Assumes rlck_defs.svh is on the include path.
 */
`include "rlck_defs.svh"

package rlck_pkg;

    typedef enum logic [5:0] {
        RLCK_IDLE  = 6'h01,
        RLCK_HDR   = 6'h02,
        RLCK_LEN   = 6'h04,
        RLCK_COPY  = 6'h08,
        RLCK_PATCH = 6'h10,
        RLCK_DONE  = 6'h20
    } rlck_state_t;

    // One byte request to the serial memory front end
    typedef struct packed {
        logic        valid;
        logic [11:0] addr;
    } rlck_rd_req_t;

    // Default resource request of the codec logical device
    typedef struct packed {
        logic [15:0] codec_io_base;
        logic [7:0]  codec_len;
        logic [7:0]  codec_align;
        logic [15:0] synth_io_base;
        logic [7:0]  synth_len;
        logic [7:0]  synth_align;
        logic [15:0] legacy_audio_io_base;
        logic [7:0]  legacy_len;
        logic [7:0]  legacy_align;
        logic        dma_8bit;
        logic        dma_count_by_byte;
        logic [1:0]  dma_timing;
    } rlck_defaults_t;

endpackage

// ==== testbench/rlck_checker.sv ====
/* Assertion checker for rlck_loader, bound to its ports.
   Assumes rlck_pkg is compiled first and one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module rlck_checker #(
    parameter int RAM_BYTES   = 384,
    parameter int PATCH_BYTES = 640
) (
    input wire logic                     i_clk,
    input wire logic                     i_srst,
    input wire rlck_pkg::rlck_rd_req_t   o_ee_req,
    input wire logic                     i_ee_rd_valid,
    input wire logic [7:0]               i_ee_rd_data,
    input wire logic                     i_host_io_wr,
    input wire logic [15:0]              i_host_io_addr,
    input wire logic [7:0]               i_host_io_data,
    input wire logic                     i_pnp_key_disable,
    input wire logic                     o_load_done,
    input wire logic                     o_ee_present,
    input wire logic                     o_pnp_ready,
    input wire logic                     o_config_mode,
    input wire logic                     o_pnp_key_enabled,
    input wire rlck_pkg::rlck_defaults_t o_defaults
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    // -------------------------------------------
    // Address of the last request seen standing
    // -------------------------------------------
    logic [11:0] last_addr;
    logic [11:0] next_last_addr;
    always_comb next_last_addr = o_ee_req.valid ? o_ee_req.addr : last_addr;
    always_ff @(posedge i_clk) last_addr <= i_srst ? 12'h000 : next_last_addr;

    sequence s_bad_byte;
        i_ee_rd_valid && ((last_addr == 12'h000 && i_ee_rd_data != 8'h55)
            || (last_addr == 12'h001 && i_ee_rd_data != 8'hBB));
    endsequence
    property p_first;
        !i_srst && $past(i_srst) |-> ##[0:2] (o_ee_req.valid && o_ee_req.addr == 12'h000);
    endproperty
    property p_hold;
        o_ee_req.valid && !i_ee_rd_valid |=>
            $stable(o_ee_req.addr) && (o_ee_req.valid || i_ee_rd_valid);
    endproperty
    property p_next;
        $rose(o_ee_req.valid) && o_ee_req.addr != 12'h000 |->
            o_ee_req.addr == last_addr + 12'h001;
    endproperty
    property p_bad;
        s_bad_byte |-> ##[1:2] (o_load_done && !o_ee_present && !o_ee_req.valid) [*4];
    endproperty
    property p_present;
        $rose(o_ee_present) |-> last_addr == 12'h003;
    endproperty
    property p_ready;
        o_pnp_ready |-> o_load_done && !o_ee_req.valid;
    endproperty
    property p_key;
        $rose(o_config_mode) |-> o_load_done && $past(i_host_io_wr)
            && $past(i_host_io_addr) == 16'h0279 && $past(i_host_io_data) == 8'h1A;
    endproperty
    property p_pnp_off;
        i_pnp_key_disable |=> (!o_pnp_key_enabled && !o_pnp_ready) [*4];
    endproperty
    property p_defaults;
        o_defaults == {16'h0534, 8'h04, 8'h04, 16'h0388, 8'h04, 8'h08,
                       16'h0220, 8'h10, 8'h20, 1'b1, 1'b1, 2'h1};
    endproperty
    a_first: assert property (p_first) else $error("first read not at byte zero");
    a_hold: assert property (p_hold) else $error("request dropped early");
    a_next: assert property (p_next) else $error("read address not ascending");
    a_bad: assert property (p_bad) else $error("bad header not treated as absent");
    a_present: assert property (p_present) else $error("present before header end");
    a_ready: assert property (p_ready) else $error("ready while loading");
    a_key: assert property (p_key) else $error("config mode without key end");
    a_pnp_off: assert property (p_pnp_off) else $error("standard key still on");
    a_defaults: assert property (p_defaults) else $error("default request wrong");
endmodule
bind rlck_loader rlck_checker #(.RAM_BYTES(RAM_BYTES), .PATCH_BYTES(PATCH_BYTES))
    rlck_checker_inst (.i_clk, .i_srst, .o_ee_req, .i_ee_rd_valid, .i_ee_rd_data,
    .i_host_io_wr, .i_host_io_addr, .i_host_io_data, .i_pnp_key_disable, .o_load_done,
    .o_ee_present, .o_pnp_ready, .o_config_mode, .o_pnp_key_enabled, .o_defaults);
`default_nettype wire

// ==== testbench/rlck_ee_model.sv ====
/* Serial memory front end model: answers each byte request after lat cycles.
   Assumes the bench fills mem and sets lat while reset is held. */
`timescale 1ns/10ps
`default_nettype none
module rlck_ee_model (
    input  wire logic                   i_clk,
    input  wire logic                   i_srst,
    input  wire rlck_pkg::rlck_rd_req_t i_req,
    output logic                        o_valid,
    output logic [7:0]                  o_data
);
    logic [7:0] mem [1024];
    int         lat = 1;
    int         wait_cnt = 0;
    initial begin
        o_valid = 1'b0;
        o_data  = 8'h00;
    end
    // Idle data toggles so a stale byte can never pass as an answer
    always @(posedge i_clk) begin
        o_valid <= 1'b0;
        o_data  <= ~o_data;
        if (i_srst) begin
            wait_cnt <= 0;
        end else if (i_req.valid && !o_valid) begin
            if (wait_cnt >= lat - 1) begin
                o_valid  <= 1'b1;
                o_data   <= mem[i_req.addr[9:0]];
                wait_cnt <= 0;
            end else begin
                wait_cnt <= wait_cnt + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench/rlck_loader_tb_top.sv ====
/* Self-checking bench for rlck_loader: boots from several images, host-loads,
   sends key sequences. Assumes the checker and memory model are compiled. */
`timescale 1ns/10ps
`default_nettype none
module rlck_loader_tb_top;
    logic                     i_clk = 1'b0;
    logic                     i_srst = 1'b1;
    logic                     i_ee_rd_valid;
    logic [7:0]               i_ee_rd_data;
    logic                     i_host_io_wr = 1'b0;
    logic [15:0]              i_host_io_addr = 16'h0000;
    logic [7:0]               i_host_io_data = 8'h00;
    logic                     i_hostload_wr = 1'b0;
    logic [8:0]               i_hostload_addr = 9'h000;
    logic [7:0]               i_hostload_data = 8'h00;
    logic [8:0]               i_res_rd_addr = 9'h000;
    logic [9:0]               i_patch_rd_addr = 10'h000;
    logic                     i_cfg_exit = 1'b0;
    logic                     i_pnp_key_disable = 1'b0;
    logic                     i_vendor_key_disable = 1'b0;
    logic [7:0]               o_res_rd_data, o_patch_rd_data;
    logic                     o_load_done, o_ee_present, o_pnp_ready;
    logic                     o_config_mode, o_pnp_key_enabled;
    logic [15:0]              o_res_length;
    rlck_pkg::rlck_rd_req_t   o_ee_req;
    rlck_pkg::rlck_defaults_t o_defaults;
    int                       errors = 0;
    int                       num_checks = 0;
    logic [7:0]               r, p;
    logic [7:0] key [32] = '{8'h96, 8'h35, 8'h9A, 8'hCD, 8'hE6, 8'hF3, 8'h79, 8'hBC,
        8'h5E, 8'hAF, 8'h57, 8'h2B, 8'h15, 8'h8A, 8'hC5, 8'hE2, 8'hF1, 8'hF8, 8'h7C,
        8'h3E, 8'h9F, 8'h4F, 8'h27, 8'h13, 8'h09, 8'h84, 8'h42, 8'hA1, 8'hD0, 8'h68,
        8'h34, 8'h1A};

    rlck_loader rlck_loader_inst (.i_clk, .i_srst, .o_ee_req, .i_ee_rd_valid,
        .i_ee_rd_data, .i_host_io_wr, .i_host_io_addr, .i_host_io_data, .i_hostload_wr,
        .i_hostload_addr, .i_hostload_data, .i_res_rd_addr, .o_res_rd_data,
        .i_patch_rd_addr, .o_patch_rd_data, .i_cfg_exit, .i_pnp_key_disable,
        .i_vendor_key_disable, .o_load_done, .o_ee_present, .o_pnp_ready, .o_config_mode,
        .o_pnp_key_enabled, .o_res_length, .o_defaults);
    rlck_ee_model rlck_ee_model_inst (.i_clk, .i_srst, .i_req(o_ee_req),
        .o_valid(i_ee_rd_valid), .o_data(i_ee_rd_data));

    always #50 i_clk = ~i_clk;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #5;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] em(input int i);
        return 8'(i) ^ 8'hA5;
    endfunction
    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
        step(1);
    endtask
    task automatic hw(input logic [15:0] a, input logic [7:0] d);
        i_host_io_addr = a;
        i_host_io_data = d;
        pulse(i_host_io_wr);
    endtask
    task automatic rd(input logic [9:0] a);
        i_res_rd_addr = a[8:0];
        i_patch_rd_addr = a;
        step(1);
        r = o_res_rd_data;
        p = o_patch_rd_data;
    endtask
    // Image: header, length high then low, then a known byte pattern
    task automatic boot(input int lat, input logic [7:0] b1, input logic [15:0] len);
        int k;
        i_srst = 1'b1;
        rlck_ee_model_inst.lat = lat;
        for (k = 0; k < 1024; k++) rlck_ee_model_inst.mem[k] = em(k);
        rlck_ee_model_inst.mem[0] = 8'h55;
        rlck_ee_model_inst.mem[1] = b1;
        rlck_ee_model_inst.mem[2] = len[15:8];
        rlck_ee_model_inst.mem[3] = len[7:0];
        step(8);
        i_srst = 1'b0;
        for (k = 0; k < 5000 && o_load_done !== 1'b1; k++) step(1);
        chk(o_load_done, 16'h0001);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_absent;
        boot(1, 8'h00, 16'h0005);
        chk(o_ee_present, 16'h0000);
        chk(o_pnp_ready, 16'h0001);
        chk(o_defaults.codec_io_base, 16'h0534);
        chk(o_defaults.synth_io_base, 16'h0388);
        chk(o_defaults.legacy_audio_io_base, 16'h0220);
        chk({o_defaults.dma_8bit, o_defaults.dma_count_by_byte, o_defaults.dma_timing}, 16'h000D);
        i_hostload_addr = 9'h007;
        i_hostload_data = 8'h3C;
        pulse(i_hostload_wr);
        rd(10'h007);
        chk(r, 16'h003C);
        $display("test absent done");
    endtask
    task automatic t_load;
        boot(3, 8'hBB, 16'h0005);
        chk(o_ee_present, 16'h0001);
        chk(o_res_length, 16'h0005);
        i_hostload_addr = 9'h000;
        pulse(i_hostload_wr);
        rd(10'h000);
        chk(r, em(4));
        chk(p, em(9));
        rd(10'h004);
        chk(r, em(8));
        rd(10'h27F);
        chk(p, em(648));
        $display("test load done");
    endtask
    task automatic t_clip;
        boot(1, 8'hBB, 16'h0190);
        chk(o_res_length, 16'h0190);
        rd(10'h17F);
        chk(r, em(387));
        rd(10'h000);
        chk(p, em(388));
        $display("test clip done");
    endtask
    task automatic t_zero;
        boot(1, 8'hBB, 16'h0000);
        chk(o_res_length, 16'h0000);
        rd(10'h000);
        chk(p, em(4));
        $display("test zero done");
    endtask
    task automatic t_key;
        int k;
        for (k = 0; k < 5; k++) hw(16'h0279, key[k]);
        hw(16'h0279, 8'h96);
        for (k = 1; k < 32; k++) begin
            if (k == 9) hw(16'h0A79, 8'h00);
            chk(o_config_mode, 16'h0000);
            hw(16'h0279, key[k]);
        end
        chk(o_config_mode, 16'h0001);
        pulse(i_cfg_exit);
        chk(o_config_mode, 16'h0000);
        pulse(i_vendor_key_disable);
        for (k = 0; k < 32; k++) hw(16'h0279, key[k]);
        chk(o_config_mode, 16'h0000);
        pulse(i_pnp_key_disable);
        chk(o_pnp_key_enabled, 16'h0000);
        chk(o_pnp_ready, 16'h0000);
        $display("test key done");
    endtask

    initial begin
        t_absent();
        t_load();
        t_clip();
        t_zero();
        t_key();
        print_verdict();
    end
    // Four boots of at most about 3000 cycles each fit well inside this span
    initial begin
        #5000000;
        errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
